// ==== rtl/itsr_map.vh ====
// Constants for the interval timer serial target and its registers
`ifndef ITSR_MAP_VH
`define ITSR_MAP_VH

// ----------------------------------------------------------------------------
// Bus address and command codes
// ----------------------------------------------------------------------------
`define ITSR_TARGET_ADDR   7'h32
`define ITSR_CLEAR_CODE    3'h2
`define ITSR_FILL_BYTE     8'hff

// ----------------------------------------------------------------------------
// Setting register layout and reset values
// ----------------------------------------------------------------------------
`define ITSR_FSEL_W        10
`define ITSR_FSEL_RESET    10'h000
`define ITSR_CLR_RESET     3'h7
`define ITSR_PTR_BIT       7
`define ITSR_FSEL_HI_BIT   7
`define ITSR_FSEL_LO_BIT   5

// ----------------------------------------------------------------------------
// Timing: oscillator and system clock
// ----------------------------------------------------------------------------
`define ITSR_OSC_HZ        32768
`define ITSR_SYS_HZ        100000000
`define ITSR_COUNT_MAX     24'hffffff

`endif

// ==== rtl/itsr_tap_gen.v ====
// Frequency tap divider and periodic output combiner
`timescale 1ns/1ns
`default_nettype none
`include "itsr_map.vh"

module itsr_tap_gen #(
  parameter integer TICK_DIV  = 48828,
  parameter         OPEN_DRAIN = 1'b0
) (
  input  wire                    clk_sys_i,
  input  wire                    nrst_i,
  input  wire                    div_clear_i,
  input  wire [`ITSR_FSEL_W-1:0] fsel_i,
  input  wire                    out_enable_i,
  output reg                     periodic_o,
  output wire                    sec_tick_o
);

  // --------------------------------------------------------------------------
  // Prescaler: 2.048 kHz step from the system clock
  // --------------------------------------------------------------------------
  reg [15:0] pre_cnt;
  reg [10:0] div_cnt;
  wire       pre_hit = (pre_cnt == TICK_DIV[15:0] - 16'h0001);

  // Divider restarts on a setting write, which may stretch one second
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_cnt <= 16'h0000;
      div_cnt <= 11'h000;
    end else if (div_clear_i) begin
      pre_cnt <= 16'h0000;
      div_cnt <= 11'h000;
    end else if (pre_hit) begin
      pre_cnt <= 16'h0000;
      div_cnt <= div_cnt + 11'h001;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  assign sec_tick_o = pre_hit && (div_cnt == 11'h7ff);

  // Taps: bit k of fsel is 2^k Hz, square wave from divider bit 10-k
  reg [`ITSR_FSEL_W-1:0] taps;
  reg                    mix;
  integer                k;
  always @* begin
    taps = {`ITSR_FSEL_W{1'b0}};
    for (k = 0; k < `ITSR_FSEL_W; k = k + 1)
      taps[k] = div_cnt[10-k];
    mix = (fsel_i != {`ITSR_FSEL_W{1'b0}}) && (&(taps | ~fsel_i));
  end

  // Open-drain style inverts the mix; disabled or empty fsel parks the pin
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      periodic_o <= OPEN_DRAIN;
    else if (!out_enable_i)
      periodic_o <= ~OPEN_DRAIN;
    else
      periodic_o <= OPEN_DRAIN ? ~mix : mix;
  end

endmodule // itsr_tap_gen
`default_nettype wire

// ==== rtl/itsr_target.v ====
// Two-wire target interface, setting register and seconds timer
`timescale 1ns/1ns
`default_nettype none
`include "itsr_map.vh"

// Contract
// - Elapsed count is 24-bit binary, readable, never writable over the bus.
// - Upper 10 setting bits enable taps; open-drain variant NANDs them.
// - Push-pull variant ANDs the enabled taps, 1 Hz to 512 Hz.
// - Clear code 0,1,0 in bits 2..0 zeroes and restarts the timer.
// - Clear leaves the frequency-select bits as written.
// - Other codes only update frequency bits; timer keeps running.
// - Bits 6..1 of first byte and 5..3 of third byte ignored.
// - Setting read valid only with enable pin high, else count bytes.
// - Data falling while clock high is a start; begin new access.
// - Data rising while clock high is a stop; return to standby.
// - Data changes only while clock low; else start or stop aborts.
// - Device drives acknowledge low for the whole ninth clock.
// - First byte is 7-bit address plus direction; answer only 0110010.
// - Direction zero writes setting; one reads setting or count.
// - Reads MSB first; master acks all but last byte, then stops.
// - Repeated start takes a new address without standby.
// - Count read returns three bytes, most significant first.
// - Bytes beyond the register length read as all ones.
// - Second byte and top two bits of third load frequency select.
// - Timer counts once per second and saturates at all ones.
// - Pointer bit 7 of first write byte; stop resets to count.
module itsr_target #(
  parameter integer TICK_DIV   = (`ITSR_SYS_HZ / `ITSR_OSC_HZ) * 16,
  parameter         OPEN_DRAIN = 1'b0
) (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire        output_enable_pin_i,
  output wire        periodic_o,
  output wire [23:0] elapsed_seconds_count_o
);

  // --------------------------------------------------------------------------
  // States of the byte engine
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;  // Standby, waiting for start
  localparam [2:0] ST_ADDR = 3'h1;  // Shifting in address byte
  localparam [2:0] ST_WDAT = 3'h2;  // Shifting in write data
  localparam [2:0] ST_RDAT = 3'h3;  // Shifting out read data
  localparam [2:0] ST_ACK  = 3'h4;  // Driving acknowledge
  localparam [2:0] ST_MACK = 3'h5;  // Sampling master acknowledge
  localparam [2:0] ST_SKIP = 3'h6;  // Not addressed, wait for start

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg       scl_d;
  reg       sda_d;

  // Two sync flops per bus pin plus a delay flop; the second stage and its delayed copy feed logic
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  reg [1:0] en_sync;
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      en_sync <= 2'h0;
    else
      en_sync <= {en_sync[0], output_enable_pin_i};
  end

  wire scl_s    = scl_sync[1];
  wire sda_s    = sda_sync[1];
  wire enable_s = en_sync[1];
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c  = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c   = scl_s && scl_d && !sda_d && sda_s;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [2:0]              state;
  reg [2:0]              bit_cnt;
  reg [7:0]              shreg;
  reg [2:0]              byte_idx;
  reg                    is_read;
  reg                    ptr_count;  // 1: count register, 0: setting
  reg                    sda_low;
  reg [`ITSR_FSEL_W-1:0] fsel;
  reg [2:0]              clr_code;
  reg [7:0]              fsel_hi;    // Held until the third byte arrives
  reg                    clr_pulse;
  reg                    set_write;
  reg [23:0]             count;
  reg [7:0]              snap_mid;
  reg [7:0]              snap_lo;
  reg [2:0]              ack_next;
  reg                    got_bit;    // A rise was seen since the byte began

  wire sec_tick;

  // Byte offered on a read; the lower two count bytes are snapshot at the address byte
  function [7:0] rd_byte;
    input [2:0]  idx;
    input        use_count;
    input [23:0] cnt;
    input [7:0]  mid;
    input [7:0]  lo;
    input [9:0]  fs;
    input [2:0]  cc;
    begin
      if (use_count) begin
        case (idx)
          3'h0:    rd_byte = cnt[23:16];
          3'h1:    rd_byte = mid;
          3'h2:    rd_byte = lo;
          default: rd_byte = `ITSR_FILL_BYTE;
        endcase
      end else begin
        case (idx)
          3'h0:    rd_byte = fs[9:2];
          3'h1:    rd_byte = {fs[1:0], 3'h0, cc};
          default: rd_byte = `ITSR_FILL_BYTE;
        endcase
      end
    end
  endfunction

  // Setting read needs enable high; else the count is returned
  wire read_count = ptr_count || !enable_s;

  // Byte to be offered next, decoded once for load and first bit
  wire [7:0] next_rd = rd_byte(byte_idx, read_count, count, snap_mid,
                               snap_lo, fsel, clr_code);

  // --------------------------------------------------------------------------
  // Byte engine
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      byte_idx  <= 3'h0;
      is_read   <= 1'b0;
      ptr_count <= 1'b1;
      sda_low   <= 1'b0;
      fsel      <= `ITSR_FSEL_RESET;
      clr_code  <= `ITSR_CLR_RESET;
      fsel_hi   <= 8'h00;
      clr_pulse <= 1'b0;
      set_write <= 1'b0;
      snap_mid  <= 8'h00;
      snap_lo   <= 8'h00;
      ack_next  <= ST_IDLE;
      got_bit   <= 1'b0;
    end else begin
      clr_pulse <= 1'b0;
      set_write <= 1'b0;
      if (stop_c) begin
        state     <= ST_IDLE;
        sda_low   <= 1'b0;
        ptr_count <= 1'b1;
      end else if (start_c) begin
        state   <= ST_ADDR;
        bit_cnt <= 3'h0;
        sda_low <= 1'b0;
        got_bit <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WDAT: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              got_bit <= 1'b1;
            end
            // Eighth fall ends the byte; the fall right after a start
            // has no bits behind it and must not end a byte
            if (scl_fall && bit_cnt == 3'h0 && got_bit) begin
              got_bit <= 1'b0;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == `ITSR_TARGET_ADDR) begin
                  is_read  <= shreg[0];
                  byte_idx <= 3'h0;
                  sda_low  <= 1'b1;
                  state    <= ST_ACK;
                  ack_next <= shreg[0] ? ST_RDAT : ST_WDAT;
                  if (shreg[0]) begin
                    snap_mid <= count[15:8];
                    snap_lo  <= count[7:0];
                  end
                end else begin
                  state <= ST_SKIP;
                end
              end else begin
                // Write bytes: pointer, setting high, setting low
                case (byte_idx)
                  3'h0: ptr_count <= shreg[`ITSR_PTR_BIT];
                  3'h1: fsel_hi <= shreg;
                  3'h2: begin
                    fsel <= {fsel_hi,
                      shreg[`ITSR_FSEL_HI_BIT:`ITSR_FSEL_LO_BIT+1]};
                    clr_code  <= shreg[2:0];
                    set_write <= 1'b1;
                    clr_pulse <= (shreg[2:0] == `ITSR_CLEAR_CODE);
                  end
                  default: ;
                endcase
                byte_idx <= (byte_idx == 3'h6) ? byte_idx : byte_idx + 3'h1;
                sda_low  <= 1'b1;
                state    <= ST_ACK;
                ack_next <= ST_WDAT;
              end
            end
          end
          ST_ACK: begin
            // Hold low through the ninth clock; on its fall release, or drive the first read bit
            if (scl_fall) begin
              if (ack_next == ST_RDAT) begin
                shreg   <= next_rd;
                sda_low <= ~next_rd[7];
              end else begin
                sda_low <= 1'b0;
              end
              bit_cnt <= 3'h0;
              state   <= ack_next;
            end
          end
          ST_RDAT: begin
            // Shift out MSB first, changing only while clock is low
            if (scl_fall) begin
              if (bit_cnt == 3'h7) begin
                sda_low <= 1'b0;
                state   <= ST_MACK;
              end else begin
                shreg   <= {shreg[6:0], 1'b1};
                sda_low <= ~shreg[6];
              end
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
          ST_MACK: begin
            // Master ack continues, no-ack waits for stop
            if (scl_rise) begin
              if (!sda_s) begin
                byte_idx <= (byte_idx == 3'h6) ? byte_idx : byte_idx + 3'h1;
                state    <= ST_ACK;
                ack_next <= ST_RDAT;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_low;

  // --------------------------------------------------------------------------
  // Seconds timer
  // --------------------------------------------------------------------------
  // Saturating count; clear restarts from zero
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      count <= 24'h000000;
    else if (clr_pulse)
      count <= 24'h000000;
    else if (sec_tick && count != `ITSR_COUNT_MAX)
      count <= count + 24'h000001;
  end

  assign elapsed_seconds_count_o = count;

  itsr_tap_gen #(
    .TICK_DIV   (TICK_DIV),
    .OPEN_DRAIN (OPEN_DRAIN)
  ) u_taps (
    .clk_sys_i    (clk_sys_i),
    .nrst_i       (nrst_i),
    .div_clear_i  (set_write),
    .fsel_i       (fsel),
    .out_enable_i (enable_s),
    .periodic_o   (periodic_o),
    .sec_tick_o   (sec_tick)
  );

endmodule // itsr_target
`default_nettype wire

// ==== verification/itsr_target_assertions.sv ====
// Pin-level checks for the interval timer serial target
`timescale 1ns/1ns
`default_nettype none
module itsr_target_assertions #(
  parameter integer TICK_DIV   = 4,
  parameter         OPEN_DRAIN = 1'b0
) (
  input wire        clk_sys_i,
  input wire        nrst_i,
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe_o,
  input wire        output_enable_pin_i,
  input wire        periodic_o,
  input wire [23:0] elapsed_seconds_count_o
);
  localparam integer SEC = 2048 * TICK_DIV;
  int          gap;
  logic [23:0] prev;
  logic [4:0]  scl_hi;
  logic [3:0]  off_n;

  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  // Counters keep the long spans out of the properties; scl_hi and off_n saturate
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap    <= 0;
      prev   <= 24'h0;
      scl_hi <= 5'h0;
      off_n  <= 4'h0;
    end else begin
      prev   <= elapsed_seconds_count_o;
      gap    <= (elapsed_seconds_count_o != prev) ? 1 : gap + 1;
      scl_hi <= !scl_i ? 5'h0 : (scl_hi == 5'h1f ? scl_hi : scl_hi + 5'h1);
      off_n  <= output_enable_pin_i ? 4'h0 : (off_n == 4'hf ? off_n : off_n + 4'h1);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_sda_only_low: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  chk_count_step: assert property (elapsed_seconds_count_o != prev |->
    elapsed_seconds_count_o == prev + 24'h1 || elapsed_seconds_count_o == 24'h0)
    else $error("count moved other than by one or to zero");
  chk_count_rate: assert property (elapsed_seconds_count_o == prev + 24'h1 |->
    gap >= SEC - 8)
    else $error("count stepped faster than once a second");
  chk_ack_clock_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  chk_ack_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("data drive dropped too soon");
  chk_idle_release: assert property (scl_hi >= 5'd24 |-> !sda_oe_o)
    else $error("data held low on idle bus");
  chk_enable_off: assert property (off_n == 4'hf |-> periodic_o == ~OPEN_DRAIN)
    else $error("periodic output not parked with enable low");
  chk_reset_zero: assert property ($rose(nrst_i) |-> elapsed_seconds_count_o == 24'h0)
    else $error("count not zero after reset");
endmodule // itsr_target_assertions
`default_nettype wire

// ==== verification/itsr_master_model.sv ====
// Behavioural two-wire bus master that drives the timer target
`timescale 1ns/1ns
`default_nettype none
module itsr_master_model (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Bus idles with both lines released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Bus phases, bit steps a quarter of a 160 ns clock; start and stop end with two half-clock steps
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Start or repeated start: data falls with clock high
  task automatic start();
    scl_o = 1'b0;
    tick(4);
    sda_low_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b1;
    tick(8);
  endtask

  // Stop: data rises with clock high
  task automatic stop();
    scl_o = 1'b0;
    tick(4);
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b0;
    tick(8);
  endtask

  // Nine bits MSB first; a 1 releases the line so the target may answer
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      scl_o = 1'b0;
      tick(4);
      sda_low_o = ~tx[i];
      tick(4);
      scl_o = 1'b1;
      tick(4);
      rx[i] = sda_i;
      tick(4);
    end
  endtask
endmodule // itsr_master_model
`default_nettype wire

// ==== verification/interval_timer_serial_regs_test.sv ====
// Self-checking bench for the interval timer serial target
`timescale 1ns/1ns
`default_nettype none
module interval_timer_serial_regs_test;
  localparam integer TDIV = 4;
  localparam integer SEC  = 2048 * TDIV;
  logic        clk_sys_i, nrst_i, enb, per, oe, sda_o_w, scl, low;
  logic [23:0] cnt;
  wire         sda_w;
  logic [9:0]  fsel;
  logic [9:0]  taps [3];
  logic [2:0]  clr;
  logic [1:0]  lv;
  logic [7:0]  b [4];
  int          err_count, n_tests, base;
  int          cyc = 0;

  // Pulled-up data wire: either party may pull it low
  assign sda_w = ~(oe | low);

  itsr_target #(.TICK_DIV(TDIV), .OPEN_DRAIN(1'b0)) dut_u (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o_w), .sda_oe_o(oe), .output_enable_pin_i(enb),
    .periodic_o(per), .elapsed_seconds_count_o(cnt));
  itsr_master_model m_u (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(low));

  // Clock and a cycle count for the seconds arithmetic
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  // ----------------------------------------------------------------------
  // Compares, bus transfers and verdict
  // ----------------------------------------------------------------------
  task automatic cmp_val(input string what, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic ack);
    logic [8:0] r;
    m_u.byte_io({d, 1'b1}, r);
    cmp_bit("ack", ack, ~r[0]);
  endtask
  // Filler bits are random so ignored fields really vary
  task automatic set_write(input logic [9:0] f, input logic [2:0] c);
    logic [7:0] j;
    j = 8'($urandom);
    m_u.start();
    wr(8'h64, 1'b1);
    wr({j[7:1], 1'b1}, 1'b1);
    wr(f[9:2], 1'b1);
    wr({f[1:0], j[5:3], c}, 1'b1);
    m_u.stop();
    fsel = f;
    clr = c;
  endtask
  // Setting reads go through a pointer write and a repeated start
  task automatic reg_read(input logic setting, input int n);
    logic [8:0] r;
    logic [7:0] j;
    j = 8'($urandom);
    m_u.start();
    if (setting) begin
      wr(8'h64, 1'b1);
      wr({1'b0, j[6:1], 1'b1}, 1'b1);
      m_u.start();
    end
    wr(8'h65, 1'b1);
    for (int i = 0; i < n; i++) begin
      m_u.byte_io({8'hff, i == n - 1}, r);
      b[i] = r[8:1];
    end
    m_u.stop();
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog beyond the expected run of about 60k cycles
  initial begin
    #900000;
    err_count++;
    summarize();
  end

  // Main sequence
  initial begin
    nrst_i = 1'b0;
    enb = 1'b0;
    fsel = 10'h0;
    clr = 3'h7;
    taps = '{10'h000, 10'h200, 10'h001};
    void'($urandom(32'h9c37));
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i) nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    m_u.start();
    wr(8'h66, 1'b0);
    m_u.stop();
    reg_read(1'b0, 4);
    cmp_val("count", 24'h0, {b[0], b[1], b[2]});
    cmp_val("fill", 24'hff, {16'h0, b[3]});
    set_write(10'($urandom), 3'h7);
    base = cyc;
    while (cyc < base + SEC * 7 / 2) @(negedge clk_sys_i);
    reg_read(1'b0, 3);
    cmp_val("count", 24'h3, {b[0], b[1], b[2]});
    set_write(10'($urandom), 3'h7);
    reg_read(1'b0, 3);
    cmp_val("count", 24'h3, {b[0], b[1], b[2]});
    cmp_val("count pin", 24'h3, cnt);
    @(negedge clk_sys_i) enb = 1'b1;
    reg_read(1'b1, 3);
    cmp_val("setting", {fsel, 3'b000, clr, 8'hff}, {b[0], b[1], b[2]});
    @(negedge clk_sys_i) enb = 1'b0;
    reg_read(1'b1, 3);
    cmp_val("count via setting", 24'h3, {b[0], b[1], b[2]});
    set_write(fsel, 3'h2);
    reg_read(1'b0, 3);
    cmp_val("cleared count", 24'h0, {b[0], b[1], b[2]});
    @(negedge clk_sys_i) enb = 1'b1;
    reg_read(1'b1, 2);
    cmp_val("kept fsel", {fsel, 3'b000}, {b[0], b[1][7:3]});
    // No tap parks the output low; the 512 Hz and 1 Hz taps must each toggle within a second
    foreach (taps[k]) begin
      set_write(taps[k], 3'h7);
      lv = 2'b00;
      repeat (SEC) @(negedge clk_sys_i) lv = lv | {per, ~per};
      cmp_val("periodic levels", {22'h0, taps[k] != 10'h0, 1'b1}, {22'h0, lv});
    end
    summarize();
  end
endmodule // interval_timer_serial_regs_test

bind itsr_target itsr_target_assertions #(.TICK_DIV(TICK_DIV), .OPEN_DRAIN(OPEN_DRAIN)) chk_u (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .output_enable_pin_i(output_enable_pin_i), .periodic_o(periodic_o),
  .elapsed_seconds_count_o(elapsed_seconds_count_o));
`default_nettype wire
